// [pkg/rcf_pkg.sv]
/*
  Package for the reset-cause flag block: register offset, bit positions,
  reset values, clock-source widths and the reset-kind encoding.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
`default_nettype none

package rcf_pkg;

  // ==========================================================================
  // register map
  localparam logic [3:0]  RCF_FLAGS_OFFSET  = 4'h0;  // reset_cause_flags
  localparam logic [3:0]  RCF_CLKSEL_OFFSET = 4'h4;  // clock source status
  localparam logic [15:0] RCF_FLAGS_MASK    = 16'hC0FF; // 13..8 read zero
  localparam logic [1:0]  RCF_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RCF_RESP_SLVERR   = 2'h2;

  // ==========================================================================
  // flag bit positions
  localparam int RCF_POR_BIT   = 0;
  localparam int RCF_BOR_BIT   = 1;
  localparam int RCF_IDLE_BIT  = 2;
  localparam int RCF_SLEEP_BIT = 3;
  localparam int RCF_WATCHDOG_TIMEOUT_FLAG_BIT  = 4;
  localparam int RCF_SWDT_BIT  = 5;
  localparam int RCF_SWR_BIT   = 6;
  localparam int RCF_EXTERNAL_PIN_RESET_FLAG_BIT  = 7;
  localparam int RCF_IOP_BIT   = 14;
  localparam int RCF_TRAP_BIT  = 15;

  // flag image right after power-on (POR and BOR flags set)
  localparam logic [15:0] RCF_FLAGS_RESET = 16'h0003;

  // write strobes cover the flag word one byte lane at a time
  localparam int          RCF_BYTE_W     = 8;
  localparam int          RCF_FLAG_BYTES = 2;

  // ==========================================================================
  // clock source fields are three bits wide
  localparam int          RCF_OSC_W   = 3;
  localparam logic [2:0]  RCF_OSC_INIT = 3'h0;

  // kind of device reset that just ended
  typedef enum logic [2:0] {
    RCF_RST_NONE,
    RCF_RST_POR,
    RCF_RST_BOR,
    RCF_RST_PIN,
    RCF_RST_WDT,
    RCF_RST_SW,
    RCF_RST_TRAP,
    RCF_RST_IOP
  } rcf_rst_kind_t;

endpackage

`default_nettype wire

// [rtl/rcf_reset_cause.sv]
/*
  Reset-cause flag register, watchdog enable and clock-source choice at
  reset, reached over AXI4-Lite. Assumes all inputs synchronous to clk,
  reset events given as one-cycle pulses in resetKind, and the caller's
  power-on reset also driving reset_n.
  Flag bits 13..8 are unimplemented and always read zero.
  All flags, the clock source and the bus freeze while clkEn is low.
*/
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - software may set or clear each flag
// - writing a one never starts a reset
// - watchdog runs if config bit unprogrammed
// - bit 4 set on timeout, cleared by power-save
// - bit 14 set on illegal op, POR/BOR clear
// - bit 1 set by BOR or POR
// - bit 0 set only by POR
// - no switching: clock from config bits
// - switching: clock chosen by reset kind
// - POR/BOR new field; others keep current field
// - flag value after reset depends on kind
module rcf_reset_cause
  import rcf_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 clkEn,
  // reset and event inputs
  input  wire rcf_rst_kind_t        resetKind,
  input  wire logic                 watchdogTimeout,
  input  wire logic                 enterSleep,
  input  wire logic                 enterIdle,
  input  wire logic                 nonvolatileWatchdogEnable,
  input  wire logic                 clockSwitchEnable,
  input  wire logic [RCF_OSC_W-1:0] newOscillatorConfigField,
  input  wire logic [RCF_OSC_W-1:0] currentOscillatorField,
  output logic                      watchdogRun,
  output logic [RCF_OSC_W-1:0]      systemClockSource,
  // axi4-lite slave
  input  wire logic [3:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [3:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  // ==========================================================================
  // write channel state
  logic        awHeld_q, awHeld_d;
  logic [3:0]  awAddr_q, awAddr_d;
  logic        wHeld_q,  wHeld_d;
  logic [31:0] wData_q,  wData_d;
  logic [3:0]  wStrb_q,  wStrb_d;
  logic        bValid_q, bValid_d;
  logic [1:0]  bResp_q,  bResp_d;
  logic        wrFire;
  logic        wrFlags;

  // read channel state
  logic        rValid_q, rValid_d;
  logic [31:0] rData_q,  rData_d;
  logic [1:0]  rResp_q,  rResp_d;

  // block state
  logic [15:0]          flags_q, flags_d;
  // software write data merged lane by lane with the stored flags
  wire logic [15:0]     swFlags;
  logic [RCF_OSC_W-1:0] clkSrc_q, clkSrc_d;

  // ==========================================================================
  // bus handshakes: address and data may arrive in either order
  // a new write half is refused while the last response is pending
  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready  = !wHeld_q && !bValid_q;
  assign s_axi_arready = !rValid_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;

  // commit only once both halves are in and no response waits
  assign wrFire  = awHeld_q && wHeld_q && !bValid_q;
  assign wrFlags = wrFire && (awAddr_q == RCF_FLAGS_OFFSET);

  // write path next state
  always_comb begin
    awHeld_d = awHeld_q;
    awAddr_d = awAddr_q;
    wHeld_d  = wHeld_q;
    wData_d  = wData_q;
    wStrb_d  = wStrb_q;
    bValid_d = bValid_q;
    bResp_d  = bResp_q;
    // accept each half on its own; the held flag of a half keeps
    // that channel refused until the write commits
    if (s_axi_awvalid && s_axi_awready) begin
      awHeld_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeld_d = 1'b1;
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
    end
    // both halves held: commit the write and raise the response
    if (wrFire) begin
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
      bValid_d = 1'b1;
      // the clock status word is read-only; writing it is refused
      if (awAddr_q == RCF_FLAGS_OFFSET) begin
        bResp_d = RCF_RESP_OKAY;
      end else begin
        bResp_d = RCF_RESP_SLVERR;
      end
    end else if (bValid_q && s_axi_bready) begin
      bValid_d = 1'b0;
    end
  end

  // read path next state; the answer is registered, so rdata stands
  // unchanged until the master takes it with rready
  always_comb begin
    rValid_d = rValid_q;
    rData_d  = rData_q;
    rResp_d  = rResp_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rValid_d = 1'b1;
      rData_d  = 32'h0000_0000;
      rResp_d  = RCF_RESP_OKAY;
      // address decode; anything unmapped answers with zero data
      if (s_axi_araddr == RCF_FLAGS_OFFSET) begin
        rData_d = {16'h0000, flags_q & RCF_FLAGS_MASK};
      end else if (s_axi_araddr == RCF_CLKSEL_OFFSET) begin
        rData_d = {29'h0000_0000, clkSrc_q};
      end else begin
        rResp_d = RCF_RESP_SLVERR;
      end
    end else if (rValid_q && s_axi_rready) begin
      rValid_d = 1'b0;
    end
  end

  // ==========================================================================
  // byte lanes of a software write: a lane whose strobe is low keeps the
  // stored flags, so a byte-wide write cannot disturb the other half
  for (genvar lane = 0; lane < RCF_FLAG_BYTES; lane++) begin : g_lane
    assign swFlags[lane*RCF_BYTE_W +: RCF_BYTE_W] =
      wStrb_q[lane] ? wData_q[lane*RCF_BYTE_W +: RCF_BYTE_W]
                    : flags_q[lane*RCF_BYTE_W +: RCF_BYTE_W];
  end

  // ==========================================================================
  // flag register: software write first, hardware events override so
  // that an event landing with a clearing write is never lost
  always_comb begin
    flags_d = flags_q;
    // a write only stores the value; nothing here requests a reset
    if (wrFlags) begin
      flags_d = swFlags;
    end
    // reset kinds shape the post-reset image
    case (resetKind)
      // power-on by event loads the same image as reset_n
      RCF_RST_POR: begin
        flags_d = RCF_FLAGS_RESET;
      end
      RCF_RST_BOR: begin
        // brown-out keeps pin, SWDT and POR flags, sets BOR, clears the rest
        flags_d                = 16'h0000;
        flags_d[RCF_EXTERNAL_PIN_RESET_FLAG_BIT]  = flags_q[RCF_EXTERNAL_PIN_RESET_FLAG_BIT];
        flags_d[RCF_SWDT_BIT]  = flags_q[RCF_SWDT_BIT];
        flags_d[RCF_POR_BIT]   = flags_q[RCF_POR_BIT];
        flags_d[RCF_BOR_BIT]   = 1'b1;
      end
      // any other kind raises only its own flag
      RCF_RST_PIN:  flags_d[RCF_EXTERNAL_PIN_RESET_FLAG_BIT] = 1'b1;
      RCF_RST_WDT:  flags_d[RCF_WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1;
      RCF_RST_SW:   flags_d[RCF_SWR_BIT]  = 1'b1;
      RCF_RST_TRAP: flags_d[RCF_TRAP_BIT] = 1'b1;
      RCF_RST_IOP:  flags_d[RCF_IOP_BIT]  = 1'b1;
      default: begin
      end
    endcase
    // power-save instruction clears timeout, then marks its mode
    if (enterSleep || enterIdle) begin
      flags_d[RCF_WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b0;
    end
    if (enterSleep) begin
      flags_d[RCF_SLEEP_BIT] = 1'b1;
    end
    if (enterIdle) begin
      flags_d[RCF_IDLE_BIT] = 1'b1;
    end
    // a live timeout pulse wins over any clear in the same cycle
    if (watchdogTimeout) begin
      flags_d[RCF_WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1;
    end
    // unimplemented bits never hold a one, whatever was written
    flags_d = flags_d & RCF_FLAGS_MASK;
  end

  // ==========================================================================
  // clock source chosen when a reset ends; trap and illegal-operation
  // kinds are not among the switching cases and keep the running source
  // like a pin reset. a reset event that arrives with clkEn low is lost
  always_comb begin
    clkSrc_d = clkSrc_q;
    if (resetKind != RCF_RST_NONE) begin
      if (!clockSwitchEnable) begin
        clkSrc_d = newOscillatorConfigField;
      end else if (resetKind == RCF_RST_POR
                   || resetKind == RCF_RST_BOR) begin
        clkSrc_d = newOscillatorConfigField;
      end else begin
        clkSrc_d = currentOscillatorField;
      end
    end
  end

  assign systemClockSource = clkSrc_q;

  // unprogrammed config bit forces the watchdog on; the config input is
  // a level and may move at any time, the software bit is flag bit 5 and
  // survives a brown-out
  assign watchdogRun = nonvolatileWatchdogEnable
                       || flags_q[RCF_SWDT_BIT];

  // ==========================================================================
  // registers, one process per group; clkEn low freezes every group,
  // handshakes included, but ready is not gated by it, so a request accepted while it is low is lost

  // write channel registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 4'h0;
      wHeld_q  <= 1'b0;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
      bValid_q <= 1'b0;
      bResp_q  <= RCF_RESP_OKAY;
    end else if (clkEn) begin
      awHeld_q <= awHeld_d;
      awAddr_q <= awAddr_d;
      wHeld_q  <= wHeld_d;
      wData_q  <= wData_d;
      wStrb_q  <= wStrb_d;
      bValid_q <= bValid_d;
      bResp_q  <= bResp_d;
    end
  end

  // read channel registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rValid_q <= 1'b0;
      rData_q  <= 32'h0000_0000;
      rResp_q  <= RCF_RESP_OKAY;
    end else if (clkEn) begin
      rValid_q <= rValid_d;
      rData_q  <= rData_d;
      rResp_q  <= rResp_d;
    end
  end

  // flag register; reset_n is the power-on event of this block
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= RCF_FLAGS_RESET;
    end else if (clkEn) begin
      flags_q <= flags_d;
    end
  end

  // clock source register; power-on starts from the initial source
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clkSrc_q <= RCF_OSC_INIT;
    end else if (clkEn) begin
      clkSrc_q <= clkSrc_d;
    end
  end

endmodule

`default_nettype wire

// [tb/rcf_reset_cause_chk.sv]
/*
  Checker for rcf_reset_cause: read answers, watchdog run and clock source.
  Assumes it sees only the top ports; bound in after the module.
*/
`timescale 1ns/1ps
`default_nettype none
module rcf_reset_cause_chk
  import rcf_pkg::*;
(
  input wire logic          clk,
  input wire logic          reset_n,
  input wire logic          clkEn,
  input wire rcf_rst_kind_t resetKind,
  input wire logic          nonvolatileWatchdogEnable,
  input wire logic          clockSwitchEnable,
  input wire logic [2:0]    newOscillatorConfigField,
  input wire logic [2:0]    currentOscillatorField,
  input wire logic          watchdogRun,
  input wire logic [2:0]    systemClockSource,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic          s_axi_bvalid
);
  // ==========================================================
  // one domain, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // steps: a read is taken, a reset event ends
  sequence arTaken;
    clkEn && s_axi_arvalid && s_axi_arready;
  endsequence
  sequence resetEnds;
    clkEn && resetKind != RCF_RST_NONE;
  endsequence
  a_read_answer: assert property (arTaken |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_wdt_forced: assert property (
    nonvolatileWatchdogEnable |-> watchdogRun) else $error("watchdog off");
  // software enable moves only by a write or a power-on event
  a_wdt_cause: assert property ($changed(watchdogRun) |->
    $changed(nonvolatileWatchdogEnable) || $rose(s_axi_bvalid)
    || $past(resetKind) == RCF_RST_POR) else $error("watchdog moved");
  a_src_fixed: assert property (resetEnds ##0 !clockSwitchEnable
    |=> systemClockSource == $past(newOscillatorConfigField))
    else $error("clock source not from config");
  a_src_new: assert property (resetEnds ##0 clockSwitchEnable
    && resetKind inside {RCF_RST_POR, RCF_RST_BOR}
    |=> systemClockSource == $past(newOscillatorConfigField))
    else $error("clock source not new field");
  a_src_keep: assert property (resetEnds ##0 clockSwitchEnable
    && resetKind inside {RCF_RST_PIN, RCF_RST_WDT, RCF_RST_SW}
    |=> systemClockSource == $past(currentOscillatorField))
    else $error("clock source not kept");
  a_src_hold: assert property (clkEn && resetKind == RCF_RST_NONE
    |=> $stable(systemClockSource)) else $error("clock source moved");
endmodule
bind rcf_reset_cause rcf_reset_cause_chk i_chk (.*);
`default_nettype wire

// [tb/rcf_reset_cause_test.sv]
/*
  Self-checking bench for rcf_reset_cause: flags through AXI4-Lite reads.
  Assumes the checker is bound in and the package compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module rcf_reset_cause_test
  import rcf_pkg::*;
;
  logic clk = 1'h0, reset_n = 1'h0, clkEn = 1'h1, watchdogTimeout = 1'h0;
  logic enterSleep = 1'h0, enterIdle = 1'h0, nonvolatileWatchdogEnable = 1'h0;
  logic clockSwitchEnable = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [2:0] newOscillatorConfigField = 3'h0, currentOscillatorField = 3'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, seed = 32'h0001_3496;
  rcf_rst_kind_t resetKind = RCF_RST_NONE;
  logic watchdogRun, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [2:0] systemClockSource;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [33:0] q [$];
  int n_mismatch = 0, checks_done = 0;
  rcf_reset_cause i_rcf_reset_cause (.*);
  // ==========================================================
  // clock, 40 ns period
  always #20 clk = ~clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // one bus cycle; the note of what must come back goes in first
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] sb,
                     input logic [33:0] e);
    logic [31:0] r;
    r = xs();
    q.push_back(e);
    if (w) begin
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, sb};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    end else begin
      // rready may come late; it rises once rvalid has been seen
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 1'h1, r[0]};
    end
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'h1;
    end while (!(w ? s_axi_bvalid : s_axi_rvalid && s_axi_rready));
    {s_axi_bready, s_axi_rready} <= 2'h0;
    @(posedge clk);
  endtask
  task automatic rf(input logic [15:0] f);
    bus(1'h0, RCF_FLAGS_OFFSET, 32'h0, 4'h0, {RCF_RESP_OKAY, 16'h0, f});
  endtask
  task automatic wf(input logic [15:0] f, input logic [3:0] sb);
    bus(1'h1, RCF_FLAGS_OFFSET, {16'h0, f}, sb, {RCF_RESP_OKAY, 32'h0});
  endtask
  // one-cycle event; clock fields and enables are reshuffled each time
  task automatic ev(input rcf_rst_kind_t k, input logic [2:0] e);
    logic [31:0] r;
    r = xs();
    @(posedge clk);
    resetKind <= k;
    {watchdogTimeout, enterSleep, enterIdle} <= e;
    {clockSwitchEnable, nonvolatileWatchdogEnable} <= r[1:0];
    {newOscillatorConfigField, currentOscillatorField} <= r[7:2];
    @(posedge clk);
    resetKind <= RCF_RST_NONE;
    {watchdogTimeout, enterSleep, enterIdle} <= 3'h0;
  endtask
  task automatic cmp(input logic [33:0] g);
    logic [33:0] e;
    e = q.pop_front();
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // answers are taken at the handshake edge, oldest note first
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) cmp({s_axi_bresp, 32'h0});
    if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata});
  end
  // a hang ends the run as a mismatch
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
  // main sequence
  initial begin
    rcf_rst_kind_t ks [5];
    logic [15:0] fs [5];
    ks = '{RCF_RST_POR, RCF_RST_PIN, RCF_RST_SW, RCF_RST_TRAP, RCF_RST_IOP};
    fs = '{16'h0003, 16'h0080, 16'h0040, 16'h8000, 16'h4000};
    repeat (5) @(posedge clk);
    reset_n <= 1'h1;
    rf(16'h0003);
    wf(16'hFFFF, 4'h3);
    rf(16'hC0FF);
    ev(RCF_RST_BOR, 3'h0);
    rf(16'h00A3);
    for (int i = 0; i < 5; i++) begin
      wf(16'h0000, 4'h3);
      ev(ks[i], 3'h0);
      rf(fs[i]);
    end
    wf(16'hFFFF, 4'h1);
    rf(16'h40FF);
    wf(16'h0020, 4'h3);
    ev(RCF_RST_NONE, 3'h4);
    rf(16'h0030);
    ev(RCF_RST_NONE, 3'h2);
    rf(16'h0028);
    ev(RCF_RST_NONE, 3'h1);
    rf(16'h002C);
    ev(RCF_RST_BOR, 3'h0);
    rf(16'h0022);
    bus(1'h1, RCF_CLKSEL_OFFSET, 32'h1, 4'hF, {RCF_RESP_SLVERR, 32'h0});
    bus(1'h0, 4'h8, 32'h0, 4'h0, {RCF_RESP_SLVERR, 32'h0});
    rf(16'h0022);
    // events offered while clkEn is low must leave no trace
    clkEn <= 1'h0;
    ev(RCF_RST_TRAP, 3'h7);
    clkEn <= 1'h1;
    rf(16'h0022);
    stop_test();
  end
endmodule
`default_nettype wire
